/* design/shps_pkg.sv */
// constants and types shared by both ends of the sync header parity stream link
package shps_pkg;
  // ----------------------------------------------------------------
  // multiblock geometry
  // ----------------------------------------------------------------
  localparam int unsigned BLOCK_BITS    = 64;
  localparam int unsigned MB_BLOCKS     = 32;
  localparam int unsigned MB_DATA_BITS  = 2048;
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam logic [4:0]  LAST_BLOCK    = 5'h1f;
  // ----------------------------------------------------------------
  // stream select values and polynomials
  // ----------------------------------------------------------------
  localparam logic [1:0]  SEL_CRC       = 2'h0;
  localparam logic [1:0]  SEL_FEC       = 2'h2;
  localparam logic [11:0] CRC_POLY      = 12'h987;
  // 0x987 writes x^12 and drops the +1, so the register taps are its low bits moved up one
  localparam logic [11:0] CRC_TAPS      = {CRC_POLY[10:0], 1'b1};  // x^9 + x^8 + x^3 + x^2 + x + 1
  localparam logic [25:0] FEC_POLY      = 26'h0220211;
  // ----------------------------------------------------------------
  // sync header encodings and fixed stream fields
  // ----------------------------------------------------------------
  localparam logic [1:0]  HDR_ONE       = 2'h1;
  localparam logic [1:0]  HDR_ZERO      = 2'h2;
  localparam int unsigned EEMB_BIT      = 22;
  localparam logic [4:0]  PILOT_BITS    = 5'h10;  // stream bits 27..31 = 0,0,0,0,1
  localparam int unsigned PILOT_LSB     = 27;

  typedef enum logic [1:0] {SHPS_CRC, SHPS_FEC, SHPS_OTHER} shps_mode_t;

  // one data bit through the crc shift register
  function automatic logic [11:0] shps_crc_step(input logic [11:0] s, input logic d);
    logic fb;
    fb = s[11] ^ d;
    return {s[10:0], 1'b0} ^ (fb ? CRC_TAPS : 12'h000);
  endfunction : shps_crc_step

  // one data bit through the fec shift register
  function automatic logic [25:0] shps_fec_step(input logic [25:0] s, input logic d);
    logic fb;
    fb = s[25] ^ d;
    return {s[24:0], 1'b0} ^ (fb ? FEC_POLY : 26'h0000000);
  endfunction : shps_fec_step

  // 64 bits, msb first as sent on the lane
  function automatic logic [11:0] shps_crc_block(input logic [11:0] s, input logic [63:0] d);
    logic [11:0] r;
    r = s;
    for (int i = 63; i >= 0; i--) r = shps_crc_step(r, d[i]);
    return r;
  endfunction : shps_crc_block

  function automatic logic [25:0] shps_fec_block(input logic [25:0] s, input logic [63:0] d);
    logic [25:0] r;
    r = s;
    for (int i = 63; i >= 0; i--) r = shps_fec_step(r, d[i]);
    return r;
  endfunction : shps_fec_block

  // builds a 32-bit stream word; bit 0 goes out first
  function automatic logic [31:0] shps_stream(input logic fec, input logic [25:0] par, input logic eemb);
    logic [31:0] w;
    w = 32'h00000000;
    if (fec) begin
      for (int i = 0; i < 22; i++) w[i] = par[25 - i];
      w[23] = par[3];
      w[24] = par[2];
      w[25] = par[1];
      w[26] = par[0];
    end else begin
      for (int g = 0; g < 4; g++) begin
        w[4*g]     = par[11 - 3*g];
        w[4*g + 1] = par[10 - 3*g];
        w[4*g + 2] = par[9 - 3*g];
        w[4*g + 3] = 1'b1;
      end
      w[19] = 1'b1;
      w[21] = 1'b1;
      w[23] = 1'b1;
    end
    w[EEMB_BIT] = eemb;
    w[31:PILOT_LSB] = PILOT_BITS;
    return w;
  endfunction : shps_stream
endpackage : shps_pkg

/* design/shps_link_if.sv */
// lane-side link between the parity stream generator and its receiver
`timescale 1ns/1ps
interface shps_link_if;
  logic        valid;   // one 66-bit block this cycle
  logic [1:0]  hdr;     // sync header, 01 = stream 1, 10 = stream 0
  logic [63:0] data;    // scrambled payload, bit 63 sent first
  logic        ready;   // receiver accepts the block

  modport tx (output valid, output hdr, output data, input ready);
  modport rx (input valid, input hdr, input data, output ready);
endinterface : shps_link_if

/* design/shps_fifo.sv */
// small valid/ready fifo used on the receiver's block path
`timescale 1ns/1ps
module shps_fifo #(
  parameter int unsigned WIDTH = 66,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  // pointers wrap on depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : shps_fifo

/* design/shps_tx.sv */
// transmit end: per-multiblock parity and sync header stream generation
`timescale 1ns/1ps
module shps_tx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // user side
  input  wire logic [1:0]  sync_header_stream_select,
  input  wire logic        extended_multiblock_last_flag,
  input  wire logic        blk_valid,
  input  wire logic [63:0] blk_data,
  output logic             blk_ready,
  output logic [4:0]       blk_index,
  // lane side
  shps_link_if.tx          link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [4:0]  idx;          // block position inside the multiblock
  logic [11:0] crc_state;
  logic [25:0] fec_state;
  logic [31:0] stream;       // word being sent in this multiblock
  logic        mode_fec;     // mode latched for the multiblock in flight
  logic        out_valid;
  logic [1:0]  out_hdr;
  logic [63:0] out_data;
  logic        take;
  logic        first;
  logic        cur_fec;
  logic        eemb_hold;
  logic [11:0] next_crc;
  logic [25:0] next_fec;
  logic        skid_valid;       // a block accepted while the lane stalls
  logic [63:0] skid_data;
  logic        next_skid_valid;
  logic        accept;           // user handshake completes this edge
  logic        core_valid;       // block offered to the generators
  logic [63:0] core_data;
  logic        core_ready;
  logic [25:0] par_hold;         // parity of the previous multiblock

  assign first     = (idx == 5'h00);
  assign cur_fec   = first ? (sync_header_stream_select == shps_pkg::SEL_FEC) : mode_fec;
  assign blk_index = idx;

  // ----------------------------------------------------------------
  // input skid register
  // ----------------------------------------------------------------
  // the user ready comes from a flip-flop, so one block may have to wait here;
  // select and flag must stand until block 0 has left this register
  assign accept     = blk_valid & blk_ready;
  assign core_valid = skid_valid | accept;
  assign core_data  = skid_valid ? skid_data : blk_data;
  // an empty output register or a drained one may take a block
  assign core_ready = ~out_valid | link.ready;
  assign take       = core_valid & core_ready;

  // the skid fills only when a block is accepted into a stalled lane
  always_comb begin
    next_skid_valid = skid_valid;
    if (accept && !core_ready) begin
      next_skid_valid = 1'b1;
    end else if (skid_valid && core_ready) begin
      next_skid_valid = 1'b0;
    end
  end

  // ready stays low in reset, so nothing is accepted then
  always_ff @(posedge clk) begin
    if (reset) begin
      skid_valid <= 1'b0;
      blk_ready  <= 1'b0;
    end else begin
      skid_valid <= next_skid_valid;
      blk_ready  <= ~next_skid_valid;
    end
  end

  // payload of the waiting block
  always_ff @(posedge clk) begin
    if (accept && !core_ready) skid_data <= blk_data;
  end

  // ----------------------------------------------------------------
  // stream layout, one position at a time
  // ----------------------------------------------------------------
  // layout follows the mode of the multiblock in flight, parity is the previous one's
  for (genvar b = 0; b < shps_pkg::PILOT_LSB; b++) begin : g_stream
    // parity bit that each mode places at this position
    localparam int FEC_SRC = (b < 22) ? 25 - b : 26 - b;
    localparam int CRC_SRC = 11 - 3 * (b / 4) - (b % 4);
    if (b == shps_pkg::EEMB_BIT) begin : g_flag
      assign stream[b] = eemb_hold;
    end else if (b < 16 && b % 4 != 3) begin : g_crc_par
      assign stream[b] = cur_fec ? par_hold[FEC_SRC] : par_hold[CRC_SRC];
    end else if (b < 16 || b == 19 || b == 21 || b == 23) begin : g_crc_one
      assign stream[b] = cur_fec ? par_hold[FEC_SRC] : 1'b1;
    end else begin : g_crc_cmd
      assign stream[b] = cur_fec & par_hold[FEC_SRC];
    end
  end

  // the pilot closes every word in both modes
  assign stream[31:shps_pkg::PILOT_LSB] = shps_pkg::PILOT_BITS;
  assign link.valid = out_valid;
  assign link.hdr   = out_hdr;
  assign link.data  = out_data;

  // ----------------------------------------------------------------
  // parity generators
  // ----------------------------------------------------------------
  // start from zero on the first block so nothing leaks across multiblocks
  always_comb begin
    next_crc = shps_pkg::shps_crc_block(first ? 12'h000 : crc_state, core_data);
    next_fec = shps_pkg::shps_fec_block(first ? 26'h0000000 : fec_state, core_data);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      crc_state <= 12'h000;
      fec_state <= 26'h0000000;
    end else if (take) begin
      crc_state <= next_crc;
      fec_state <= next_fec;
    end
  end

  // block counter and mode latch; mode changes only at a multiblock edge
  always_ff @(posedge clk) begin
    if (reset) begin
      idx      <= 5'h00;
      mode_fec <= 1'b0;
    end else if (take) begin
      idx <= idx + 5'h01;
      if (first) mode_fec <= cur_fec;
    end
  end

  // ----------------------------------------------------------------
  // parity hand-over: what one multiblock computes, the next one carries
  // ----------------------------------------------------------------
  // only the parity is held, so the first multiblock after reset sends zero parity in either mode
  always_ff @(posedge clk) begin
    if (reset) begin
      par_hold <= 26'h0000000;
    end else if (take && idx == shps_pkg::LAST_BLOCK) begin
      // crc parity occupies the low 12 bits
      par_hold <= mode_fec ? next_fec : {14'h0000, next_crc};
    end
  end

  // the eemb flag is caught with block 0, so it belongs to the multiblock being sent
  always_ff @(posedge clk) begin
    if (reset) begin
      eemb_hold <= 1'b0;
    end else if (take && first) begin
      eemb_hold <= extended_multiblock_last_flag;
    end
  end

  // ----------------------------------------------------------------
  // lane output register
  // ----------------------------------------------------------------
  // bit idx of the stream rides on block idx, pilot finishing on block 31
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_hdr   <= shps_pkg::HDR_ZERO;
      out_data  <= 64'h0000000000000000;
    end else begin
      if (link.ready) out_valid <= 1'b0;
      if (take) begin
        out_valid <= 1'b1;
        out_data  <= core_data;
        // header comes from the word position that matches the block
        out_hdr   <= stream[idx] ? shps_pkg::HDR_ONE : shps_pkg::HDR_ZERO;
      end
    end
  end
endmodule : shps_tx

/* design/shps_rx.sv */
// receive end: recomputes parity, checks it and tracks multiblock alignment
`timescale 1ns/1ps
module shps_rx (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // user side
  input  wire logic [1:0]  sync_header_stream_select,
  output logic             blk_valid,
  output logic [63:0]      blk_data,
  input  wire logic        blk_ready,
  output logic             mb_done,
  output logic             parity_error,
  output logic             extended_multiblock_last_flag,
  output logic             multiblock_end_pilot,
  output logic             header_error,
  output logic             aligned,
  // lane side
  shps_link_if.rx          link
);
  logic        f_valid;
  logic [65:0] f_data;
  logic        f_ready;
  logic [4:0]  idx;
  logic [31:0] sh;
  logic [11:0] crc_state;
  logic [25:0] fec_state;
  logic [25:0] par_prev;     // locally computed parity of the previous multiblock
  logic        have_prev;
  logic [1:0]  pilot_hits;
  logic        fec;
  logic        take;
  logic        bit_in;
  logic [31:0] next_sh;
  logic [11:0] next_crc;
  logic [25:0] next_fec;
  logic [31:0] expect_w;

  // lane blocks buffered so the user side can stall the link
  shps_fifo #(.WIDTH(66), .DEPTH(shps_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (link.valid),
    .in_data   ({link.hdr, link.data}),
    .in_ready  (link.ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  assign f_ready = ~blk_valid | blk_ready;
  assign take    = f_valid & f_ready;
  assign fec     = (sync_header_stream_select == shps_pkg::SEL_FEC);
  assign bit_in  = (f_data[65:64] == shps_pkg::HDR_ONE);

  // local parity and stream assembly for the block being taken
  always_comb begin
    next_sh       = sh;
    next_sh[idx]  = bit_in;
    next_crc      = shps_pkg::shps_crc_block(idx == 5'h00 ? 12'h000 : crc_state, f_data[63:0]);
    next_fec      = shps_pkg::shps_fec_block(idx == 5'h00 ? 26'h0000000 : fec_state, f_data[63:0]);
    expect_w      = shps_pkg::shps_stream(fec, par_prev, next_sh[shps_pkg::EEMB_BIT]);
  end

  // parity engines and counters
  always_ff @(posedge clk) begin
    if (reset) begin
      idx       <= 5'h00;
      sh        <= 32'h00000000;
      crc_state <= 12'h000;
      fec_state <= 26'h0000000;
      par_prev  <= 26'h0000000;
      have_prev <= 1'b0;
    end else if (take) begin
      idx       <= idx + 5'h01;
      sh        <= next_sh;
      crc_state <= next_crc;
      fec_state <= next_fec;
      if (idx == shps_pkg::LAST_BLOCK) begin
        par_prev  <= fec ? next_fec : {14'h0000, next_crc};
        have_prev <= 1'b1;
      end
    end
  end

  // user outputs; mismatch of the whole word stands for a nonzero syndrome
  always_ff @(posedge clk) begin
    if (reset) begin
      blk_valid     <= 1'b0;
      blk_data      <= 64'h0000000000000000;
      mb_done       <= 1'b0;
      parity_error  <= 1'b0;
      extended_multiblock_last_flag <= 1'b0;
      multiblock_end_pilot <= 1'b0;
      header_error  <= 1'b0;
      pilot_hits    <= 2'h0;
      aligned       <= 1'b0;
    end else begin
      if (blk_ready) blk_valid <= 1'b0;
      mb_done      <= 1'b0;
      header_error <= take & (f_data[65] == f_data[64]);
      if (take) begin
        blk_valid <= 1'b1;
        blk_data  <= f_data[63:0];
        if (idx == shps_pkg::LAST_BLOCK) begin
          mb_done <= 1'b1;
          parity_error <= have_prev & (next_sh != expect_w);
          extended_multiblock_last_flag <= next_sh[shps_pkg::EEMB_BIT];
          multiblock_end_pilot <= (next_sh[31:shps_pkg::PILOT_LSB] == shps_pkg::PILOT_BITS);
          // alignment needs the pilot twice running, since fec words can mimic it
          if (next_sh[31:shps_pkg::PILOT_LSB] == shps_pkg::PILOT_BITS) begin
            if (pilot_hits != 2'h2) pilot_hits <= pilot_hits + 2'h1;
            aligned <= (pilot_hits != 2'h0);
          end else begin
            pilot_hits <= 2'h0;
            aligned    <= 1'b0;
          end
        end
      end
    end
  end
endmodule : shps_rx

/* test/shps_link_assertions.sv */
// concurrent checks on the lane link between the two ends
`timescale 1ns/1ps
module shps_link_assertions (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // lane signals
  input  wire logic        valid,
  input  wire logic [1:0]  hdr,
  input  wire logic [63:0] data,
  input  wire logic        ready
);
  logic [4:0] pos;    // position of the next block in its multiblock
  logic       first;  // first multiblock after reset, parity still zero

  // ----------------------------------------------------------------
  // block position tracking
  // ----------------------------------------------------------------
  // counts transfers only, so a stalled block keeps its position
  always_ff @(posedge clk) begin
    if (reset) begin
      pos <= 5'h00;
    end else if (valid && ready) begin
      pos <= pos + 5'h01;
    end
  end

  // cleared after the last block of the first multiblock
  always_ff @(posedge clk) begin
    if (reset) begin
      first <= 1'b1;
    end else if (valid && ready && pos == 5'h1f) begin
      first <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_hdr_legal: assert property (valid |-> hdr == 2'h1 || hdr == 2'h2)
    else $error("illegal sync header on lane");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !valid && hdr == 2'h2)
    else $error("lane not idle in reset");
  a_wake_idle: assert property ($fell(reset) |-> !valid)
    else $error("lane valid too early after reset");
  a_stall_hold: assert property (valid && !ready |=> valid && $stable(hdr) && $stable(data))
    else $error("stalled block changed");
  a_valid_release: assert property ($fell(valid) |-> $past(ready))
    else $error("block withdrawn before accept");
  a_pilot_zeros: assert property (valid && pos >= 5'h1b && pos != 5'h1f |-> hdr == 2'h2)
    else $error("pilot zero position wrong");
  a_pilot_end: assert property (valid && pos == 5'h1f |-> hdr == 2'h1)
    else $error("pilot end position wrong");
  a_first_parity: assert property (valid && first && pos < 5'h03 |-> hdr == 2'h2)
    else $error("first multiblock parity not zero");
endmodule : shps_link_assertions

/* test/tb.sv */
// self-checking bench: both link ends joined through the interface
`timescale 1ns/1ps
module tb;
  logic        clk, reset, teemb, bv, trdy, rv, rrdy, mbd, pe, re, rp, he, al, hold, herr;
  logic [1:0]  tsel, rsel;
  logic [63:0] bd, rd;
  logic [31:0] sw;
  int          error_cnt, total_checks, k_lnk, n_mb, hc;
  logic [31:0] sq[$];
  logic        eq[$];
  logic [63:0] dq[$];
  logic        mm;
  logic [4:0]  bix;
  // phases: tx select, rx select; phase 3 is a deliberate mode mismatch
  localparam logic [3:0] PH[4] = '{4'h0, 4'ha, 4'hc, 4'h2};
  assign mm = (tsel == 2'h2) != (rsel == 2'h2);

  // ----------------------------------------------------------------
  // ends, link and checker
  // ----------------------------------------------------------------
  shps_link_if shps_link_if_i ();
  shps_tx shps_tx_i (.clk(clk), .reset(reset), .sync_header_stream_select(tsel),
    .extended_multiblock_last_flag(teemb), .blk_valid(bv), .blk_data(bd), .blk_ready(trdy),
    .blk_index(bix), .link(shps_link_if_i));
  shps_rx shps_rx_i (.clk(clk), .reset(reset), .sync_header_stream_select(rsel), .blk_valid(rv),
    .blk_data(rd), .blk_ready(rrdy), .mb_done(mbd), .parity_error(pe), .extended_multiblock_last_flag(re),
    .multiblock_end_pilot(rp), .header_error(he), .aligned(al), .link(shps_link_if_i));
  shps_link_assertions shps_link_assertions_i (.clk(clk), .reset(reset), .valid(shps_link_if_i.valid),
    .hdr(shps_link_if_i.hdr), .data(shps_link_if_i.data), .ready(shps_link_if_i.ready));

  // ----------------------------------------------------------------
  // reference model and reporting
  // ----------------------------------------------------------------
  // bitwise shift, msb first as on the lane
  function automatic logic [25:0] pupd(logic [25:0] s, logic [63:0] d, logic f);
    logic fb;
    for (int i = 63; i >= 0; i--) begin
      fb = d[i] ^ (f ? s[25] : s[11]);
      // crc taps below the implied x^12: x^9 + x^8 + x^3 + x^2 + x + 1
      s = f ? {s[24:0], 1'b0} ^ (fb ? 26'h0220211 : 26'h0) : {14'h0, s[10:0], 1'b0} ^ (fb ? 26'h30f : 26'h0);
    end
    return s;
  endfunction : pupd

  function automatic logic [31:0] strm(logic f, logic [25:0] p, logic e);
    logic [31:0] w;
    w = 32'h00000000;
    for (int i = 0; i < 27; i++) if (f && i != 22) w[i] = p[25 - i + int'(i > 22)];
    for (int g = 0; g < 4; g++) if (!f) w[4*g +: 4] = {1'b1, p[9-3*g], p[10-3*g], p[11-3*g]};
    if (!f) w[23:19] = 5'h15;
    w[22] = e;
    w[31:27] = 5'h10;
    return w;
  endfunction : strm

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // clock, watchdog and monitors
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a run needs about 700 cycles, so this only cuts real hangs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  // gathers the header stream of each multiblock from the wire
  always @(posedge clk) begin
    if (reset) k_lnk = 0;
    else if (shps_link_if_i.valid && shps_link_if_i.ready) begin
      sw[k_lnk] = shps_link_if_i.hdr == 2'h1;
      if (k_lnk == 31) chk("stream", sw, sq.pop_front());
      k_lnk = (k_lnk + 1) % 32;
    end
  end

  // receiver outputs against what was sent
  always @(posedge clk) begin
    if (he) herr = 1'b1;
    if (reset) n_mb = 0;
    else begin
      if (rv && rrdy) chk("rx data", rd, dq.pop_front());
      if (mbd) begin
        chk("eemb flag", re, eq.pop_front());
        chk("pilot", rp, 1);
        if (n_mb > 0 || !mm) chk("parity error", pe, n_mb > 0 && mm);
        if (n_mb > 1 && !mm) chk("aligned", al, 1);
        n_mb++;
      end
    end
  end

  // random receiver stalls; a long one at the start of one phase fills the fifo
  always @(posedge clk) begin
    hc = reset ? 0 : hc + 1;
    if (hold && hc == 40) chk("link full", shps_link_if_i.ready, 0);
    #1 rrdy = (hold && hc < 41) ? 1'b0 : 1'($urandom % 4 != 0);
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [25:0] acc, prev;
    logic [63:0] d;
    {reset, bv, teemb, rrdy, herr, hold} = 6'h20;
    {bd, tsel, rsel} = '0;
    {error_cnt, total_checks, hc, k_lnk, n_mb} = '0;
    void'($urandom(39));
    foreach (PH[i]) begin
      {tsel, rsel} = PH[i];
      hold = i == 1;
      reset = 1'b1;
      sq.delete();
      eq.delete();
      dq.delete();
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      prev = '0;
      for (int m = 0; m < 3; m++) begin
        acc = '0;
        teemb = (m == 2) ? 1'b1 : 1'($urandom % 2);
        sq.push_back(strm(tsel == 2'h2, prev, teemb));
        eq.push_back(teemb);
        for (int k = 0; k < 32; k++) begin
          d = (m == 0 && k == 0) ? '1 : {$urandom, $urandom};
          dq.push_back(d);
          acc = pupd(acc, d, tsel == 2'h2);
          bv = 1'b1;
          bd = d;
          do @(posedge clk); while (!trdy);
          chk("blk index", bix, k);
          #1;
        end
        prev = acc;
      end
      bv = 1'b0;
      for (int w = 0; w < 400 && dq.size() > 0; w++) @(posedge clk);
      repeat (4) @(posedge clk);
      chk("drained", dq.size(), 0);
      chk("mb count", eq.size(), 0);
      chk("rx empty", rv, 0);
      #1;
    end
    chk("header error", herr, 0);
    stop_test();
  end
endmodule : tb
